// ### rtl/uhr_hub_repeater.sv
// hub repeater, downstream port state manager and hub port registers
//
// Contract
// - root port 0, internal port 1, external ports 2 to 5.
// - powered-off port gives no power, ignores upstream traffic, drivers off.
// - after reset port is disconnected; a connect moves it to disabled.
// - disabled port passes only downstream reset, no upstream while hub awake.
// - disabled port on suspended hub detects disconnect and requests resume.
// - enabled port forwards traffic both ways.
// - suspend waits for the transaction in flight to finish.
// - suspended port blocks all but reset; on suspended hub passes resume.
// - root port is the only upstream port, always powered and enabled.
// - external ports need power-on, connect and enable before any packet.
// - internal port always powered and connected, but disabled until enabled.
// - states follow hardware events and commands; packets only through enabled.
// - connectivity set up per packet, each direction, idle between packets.
// - downstream to all eligible ports; at most one port upstream.
// - connection depends on port speed; low-speed packets marked by preamble.
// - switching fast enough for hub propagation limits.
// - hub also answers device and hub class requests as a device.
// - 3-bit index selects port behind command, status and change registers.
// - 3-bit command enables, disables, resets, suspends or resumes port.
// - change register flags reset, suspend, enable and connect changes.
// - status shows line levels, low speed, power, reset, suspend, enable, connect.
// - power register switches ports 2 to 5 at bits 2 to 5; bit 1 has no effect, port 1 always powered.
// - full-speed packets only to full-speed enabled ports; end of packet idles.
// - several ports starting at once still yields one upstream connection.
// - low-speed packets to all enabled after preamble; invert; no preamble up.
`default_nettype none
module uhr_hub_repeater
    import uhr_pkg::*;
#(
    parameter int PORT_RESET_US = 10
)(
    input wire logic core_clk, // 200 mhz core clock
    input wire logic rst_b, // synchronous reset, active low
    input wire uhr_sfr_t sfr, // cpu register access
    output logic [7:0] sfr_rdata_q, // read data, one cycle after rd
    input wire logic hub_suspended, // hub itself in suspend
    input wire logic up_sop, // start of packet from host
    input wire logic up_eop, // end of packet from host
    input wire logic up_pre, // preamble seen by serial engine
    input wire uhr_port_t [NUM_DN:1] port_in, // downstream line sense
    output logic [NUM_DN:1] dn_power_q, // downstream power switch
    output logic [NUM_DN:1] dn_fwd_q, // host traffic driven onto port
    output logic [NUM_DN:1] dn_oe_q, // port output drivers enabled
    output logic [NUM_DN:1] dn_reset_q, // reset signaling on port
    output logic [NUM_DN:1] dn_invert_q, // invert data at low-speed port
    output logic [2:0] up_sel_q, // port repeated upstream, 0 none
    output logic resume_q, // resume request toward root port
    output logic [7:0] hub_addr_q // device address for token decode
);
    localparam int RST_CYC = (PORT_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_CYC);
    localparam logic [RST_CNT_W-1:0] RST_ONE = RST_CNT_W'(1);
    // reset-done flag sits in the top bit of the 4-bit per-port change store
    localparam int CHG_RST = 3;

    // lowest numbered set port, 0 when none
    function automatic logic [2:0] first_port(input logic [NUM_DN:1] v);
        logic [2:0] r;
        r = NO_PORT;
        for (int i = NUM_DN; i >= 1; i--)
        begin
            if (v[i])
                r = 3'(i);
        end
        return r;
    endfunction

    // one-hot mask of a port number
    function automatic logic [NUM_DN:1] port_bit(input logic [2:0] n);
        logic [NUM_DN:1] r;
        r = '0;
        for (int i = 1; i <= NUM_DN; i++)
        begin
            if (n == 3'(i))
                r[i] = 1'b1;
        end
        return r;
    endfunction

    uhr_pstate_t st_q [NUM_DN:1];
    uhr_pstate_t st_d [NUM_DN:1];
    logic [RST_CNT_W-1:0] rcnt_q [NUM_DN:1];
    logic [RST_CNT_W-1:0] rcnt_d [NUM_DN:1];
    logic [3:0] chg_q [NUM_DN:1];
    logic [3:0] chg_d [NUM_DN:1];
    logic [3:0] chg_set [NUM_DN:1];
    logic [NUM_DN:1] pend_q;
    logic [NUM_DN:1] pend_d;
    logic [NUM_DN:1] wake_req;
    logic [7:0] pwr_q;
    logic [2:0] idx_q;
    logic [7:0] ie_q;
    logic [7:0] hub_status_config_q;
    logic [7:0] iflg_q;
    uhr_rep_t rep_q;
    uhr_rep_t rep_d;
    logic [NUM_DN:1] fwd_d;
    logic [2:0] sel_d;
    logic [7:0] rd_d;

    // register decode
    wire wr_haddr = sfr.wr && sfr.addr == OFF_HADDR;
    wire wr_pwr = sfr.wr && sfr.addr == OFF_PWR;
    wire wr_ie = sfr.wr && sfr.addr == OFF_IE;
    wire wr_hub_status_config = sfr.wr && sfr.addr == OFF_HUB_STATUS_CONFIG;
    wire wr_pcmd = sfr.wr && sfr.addr == OFF_PCMD;
    wire wr_idx = sfr.wr && sfr.addr == OFF_IDX;
    wire wr_chg = sfr.wr && sfr.addr == OFF_CHG;
    wire wr_iflg = sfr.wr && sfr.addr == OFF_IFLG;
    wire idx_ok = idx_q >= 3'(INT_PORT) && idx_q <= 3'(NUM_DN);
    wire [NUM_DN:1] idx_bit = idx_ok ? port_bit(idx_q) : '0;
    wire uhr_cmd_t cmd = uhr_cmd_t'(sfr.wdata[2:0]);

    // state masks
    logic [NUM_DN:1] ena_mask;
    logic [NUM_DN:1] off_mask;
    logic [NUM_DN:1] ls_mask;
    logic [NUM_DN:1] rst_mask;
    logic [NUM_DN:1] off_next;
    logic [NUM_DN:1] busy;
    always_comb
    begin
        for (int i = 1; i <= NUM_DN; i++)
        begin
            ena_mask[i] = st_q[i] == PS_ENA;
            off_mask[i] = st_q[i] == PS_OFF;
            ls_mask[i] = port_in[i].low_speed;
            rst_mask[i] = rcnt_q[i] != '0;
            off_next[i] = st_d[i] == PS_OFF;
        end
    end
    assign busy = dn_fwd_q | port_bit(up_sel_q);

    // per-port state machine
    for (genvar p = 1; p <= NUM_DN; p++)
    begin : g_port
        wire powered = (p == INT_PORT) || pwr_q[p];
        wire conn = (p == INT_PORT) || port_in[p].connect;
        wire cmd_here = wr_pcmd && idx_bit[p];
        wire in_reset = rcnt_q[p] != '0;
        always_comb
        begin
            st_d[p] = st_q[p];
            rcnt_d[p] = rcnt_q[p];
            pend_d[p] = pend_q[p];
            chg_set[p] = '0;
            wake_req[p] = 1'b0;
            if (!powered)
            begin
                st_d[p] = PS_OFF;
                rcnt_d[p] = '0;
                pend_d[p] = 1'b0;
            end
            else if (st_q[p] == PS_OFF)
                st_d[p] = PS_DISC;
            else if (!conn && st_q[p] != PS_DISC)
            begin
                st_d[p] = PS_DISC;
                rcnt_d[p] = '0;
                pend_d[p] = 1'b0;
                chg_set[p][CF_CONN] = 1'b1;
                wake_req[p] = hub_suspended && st_q[p] == PS_DIS;
            end
            else if (in_reset)
            begin
                rcnt_d[p] = rcnt_q[p] - RST_ONE;
                if (rcnt_q[p] == RST_ONE)
                begin
                    st_d[p] = PS_ENA;
                    chg_set[p][CHG_RST] = 1'b1;
                end
            end
            else
            begin
                unique case (st_q[p])
                    PS_OFF:
                        st_d[p] = PS_DISC;
                    PS_DISC:
                    begin
                        if (conn)
                        begin
                            st_d[p] = PS_DIS;
                            chg_set[p][CF_CONN] = 1'b1;
                        end
                    end
                    PS_DIS:
                    begin
                        if (cmd_here && cmd == CMD_ENABLE)
                        begin
                            st_d[p] = PS_ENA;
                            chg_set[p][CF_ENA] = 1'b1;
                        end
                    end
                    PS_ENA:
                    begin
                        if (cmd_here && cmd == CMD_DISABLE)
                        begin
                            st_d[p] = PS_DIS;
                            chg_set[p][CF_ENA] = 1'b1;
                            pend_d[p] = 1'b0;
                        end
                        else if ((cmd_here && cmd == CMD_SUSPEND) || pend_q[p])
                        begin
                            pend_d[p] = busy[p];
                            if (!busy[p])
                            begin
                                st_d[p] = PS_SUSP;
                                chg_set[p][CF_SUSP] = 1'b1;
                            end
                        end
                    end
                    PS_SUSP:
                    begin
                        wake_req[p] = hub_suspended && port_in[p].sop;
                        if (cmd_here && cmd == CMD_RESUME)
                        begin
                            st_d[p] = PS_ENA;
                            chg_set[p][CF_SUSP] = 1'b1;
                        end
                        else if (cmd_here && cmd == CMD_DISABLE)
                        begin
                            st_d[p] = PS_DIS;
                            chg_set[p][CF_ENA] = 1'b1;
                        end
                    end
                endcase
                if (cmd_here && cmd == CMD_RESET && st_q[p] != PS_DISC)
                    rcnt_d[p] = RST_LOAD;
            end
            // write one clears, a new event wins
            chg_d[p] = (chg_q[p] & ~((wr_chg && idx_bit[p]) ? {sfr.wdata[CF_RST], sfr.wdata[CF_SUSP:CF_CONN]}
                : 4'h0)) | chg_set[p];
        end
        // port state registers
        always_ff @(posedge core_clk)
        begin
            if (!rst_b)
            begin
                st_q[p] <= PS_DISC;
                rcnt_q[p] <= '0;
                chg_q[p] <= '0;
                pend_q[p] <= 1'b0;
            end
            else
            begin
                st_q[p] <= st_d[p];
                rcnt_q[p] <= rcnt_d[p];
                chg_q[p] <= chg_d[p];
                pend_q[p] <= pend_d[p];
            end
        end
    end

    // repeater: per-packet connectivity, clocked, one cycle to the outputs
    always_comb
    begin
        rep_d = rep_q;
        fwd_d = dn_fwd_q & ena_mask;
        sel_d = up_sel_q;
        unique case (rep_q)
            REP_IDLE:
            begin
                fwd_d = '0;
                sel_d = NO_PORT;
                if (up_sop)
                begin
                    rep_d = REP_DOWN;
                    fwd_d = ena_mask & ~ls_mask;
                end
                else if (|(port_in_sop() & ena_mask))
                begin
                    rep_d = REP_UP;
                    sel_d = first_port(port_in_sop() & ena_mask);
                end
            end
            REP_DOWN:
            begin
                if (up_eop)
                begin
                    rep_d = REP_IDLE;
                    fwd_d = '0;
                end
                else if (up_pre)
                    fwd_d = ena_mask;
            end
            REP_UP:
            begin
                if (up_sel_q == NO_PORT || port_in[up_sel_q].eop || !ena_mask[up_sel_q])
                begin
                    rep_d = REP_IDLE;
                    sel_d = NO_PORT;
                end
            end
            default:
            begin
                rep_d = REP_IDLE;
                fwd_d = '0;
                sel_d = NO_PORT;
            end
        endcase
    end

    function automatic logic [NUM_DN:1] port_in_sop();
        logic [NUM_DN:1] r;
        for (int i = 1; i <= NUM_DN; i++)
            r[i] = port_in[i].sop;
        return r;
    endfunction

    // repeater and output registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rep_q <= REP_IDLE;
            dn_fwd_q <= '0;
            up_sel_q <= NO_PORT;
            dn_oe_q <= '0;
            dn_reset_q <= '0;
            dn_invert_q <= '0;
            dn_power_q <= '0;
            resume_q <= 1'b0;
        end
        else
        begin
            rep_q <= rep_d;
            dn_fwd_q <= fwd_d;
            up_sel_q <= sel_d;
            dn_reset_q <= rst_mask & ~off_next;
            dn_oe_q <= (fwd_d | rst_mask) & ~off_next; // drivers drop with the power
            dn_invert_q <= (fwd_d | port_bit(sel_d)) & ls_mask;
            dn_power_q <= pwr_q[NUM_DN:1] | NUM_DN'(1 << INT_PORT) >> 1;
            resume_q <= |wake_req;
        end
    end

    // register file writes
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            hub_addr_q <= REG_RST;
            pwr_q <= REG_RST;
            idx_q <= '0;
            ie_q <= REG_RST;
            hub_status_config_q <= REG_RST;
            iflg_q <= REG_RST;
        end
        else
        begin
            if (wr_haddr)
                hub_addr_q <= sfr.wdata;
            if (wr_pwr)
                pwr_q <= sfr.wdata & PWR_MASK;
            if (wr_idx)
                idx_q <= sfr.wdata[2:0];
            if (wr_ie)
                ie_q <= sfr.wdata;
            if (wr_hub_status_config)
                hub_status_config_q <= sfr.wdata;
            if (wr_iflg)
                iflg_q <= iflg_q & ~sfr.wdata;
        end
    end

    // indexed status view
    logic [7:0] view;
    logic [7:0] chg_view;
    always_comb
    begin
        view = '0;
        chg_view = '0;
        if (idx_q == ROOT_IDX)
        begin
            view[SV_PWR] = 1'b1;
            view[SV_ENA] = 1'b1;
            view[SV_CONN] = 1'b1;
        end
        for (int i = 1; i <= NUM_DN; i++)
        begin
            if (idx_bit[i])
            begin
                view[SV_DP] = port_in[i].dplus;
                view[SV_DM] = port_in[i].dminus;
                view[SV_PWR] = !off_mask[i];
                view[SV_LS] = port_in[i].low_speed;
                view[SV_RST] = rst_mask[i];
                view[SV_SUSP] = st_q[i] == PS_SUSP;
                view[SV_ENA] = ena_mask[i];
                view[SV_CONN] = st_q[i] != PS_OFF && st_q[i] != PS_DISC;
                chg_view[CF_RST] = chg_q[i][CHG_RST];
                chg_view[CF_SUSP:CF_CONN] = chg_q[i][2:0];
            end
        end
        unique case (sfr.addr)
            OFF_HADDR: rd_d = hub_addr_q;
            OFF_PWR: rd_d = pwr_q;
            OFF_IE: rd_d = ie_q;
            OFF_HUB_STATUS_CONFIG: rd_d = hub_status_config_q;
            OFF_PCMD: rd_d = REG_RST;
            OFF_IDX: rd_d = {5'h00, idx_q};
            OFF_CHG: rd_d = chg_view;
            OFF_VIEW: rd_d = view;
            OFF_IFLG: rd_d = iflg_q;
            default: rd_d = REG_RST;
        endcase
    end

    // read data register
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            sfr_rdata_q <= REG_RST;
        else if (sfr.rd)
            sfr_rdata_q <= rd_d;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_down_start;
        rep_q == REP_IDLE && up_sop;
    endsequence

    fwd_only_ena_a: assert property ((dn_fwd_q & ~ena_mask) == '0 || $past(!rst_b) || $changed(ena_mask))
        else $error("traffic forwarded to a port that is not enabled");
    one_upstream_a: assert property (up_sel_q <= 3'(NUM_DN))
        else $error("bad upstream port selection");
    fs_only_a: assert property (s_down_start |=> (dn_fwd_q & $past(ls_mask)) == '0)
        else $error("full-speed packet reached a low-speed port");
    eop_idle_a: assert property (rep_q == REP_DOWN && up_eop |=> rep_q == REP_IDLE && dn_fwd_q == '0)
        else $error("repeater did not idle at end of packet");
    pre_all_a: assert property (rep_q == REP_DOWN && up_pre && !up_eop |=> dn_fwd_q == $past(ena_mask))
        else $error("low-speed packet not sent to all enabled ports");
    off_hiz_a: assert property ((dn_oe_q & off_mask) == '0)
        else $error("drivers enabled on powered-off port");
    int_powered_a: assert property (st_q[INT_PORT] != PS_OFF)
        else $error("internal port lost power");
    susp_defer_a: assert property (st_q[2] == PS_ENA && busy[2] |=> st_q[2] != PS_SUSP)
        else $error("port suspended mid transaction");
    chg_wins_a: assert property (chg_set[INT_PORT][CF_CONN] |=> chg_q[INT_PORT][CF_CONN])
        else $error("change event lost");
    bad_idx_a: assert property (sfr.rd && sfr.addr == OFF_VIEW && !idx_ok && idx_q != ROOT_IDX
        |=> sfr_rdata_q == REG_RST)
        else $error("status of missing port not zero");
    resume_a: assert property (hub_suspended && st_q[3] == PS_DIS && pwr_q[3] && !port_in[3].connect
        |=> resume_q)
        else $error("no resume on disconnect during suspend");
    rst_end_a: assert property (rcnt_q[3] == RST_ONE && pwr_q[3] && port_in[3].connect
        |=> st_q[3] == PS_ENA && chg_q[3][CHG_RST])
        else $error("port reset did not complete");
endmodule
`default_nettype wire

// ### rtl/uhr_pkg.sv
// package: register map, field layout, enums and carriers for the hub repeater
`default_nettype none
package uhr_pkg;
    // port numbering
    localparam int NUM_DN = 5;
    localparam int INT_PORT = 1;
    localparam logic [2:0] ROOT_IDX = 3'h0;
    localparam logic [2:0] NO_PORT = 3'h0;
    // register offsets
    localparam logic [7:0] OFF_HADDR = 8'h97;
    localparam logic [7:0] OFF_PWR = 8'h9A;
    localparam logic [7:0] OFF_IE = 8'hA1;
    localparam logic [7:0] OFF_HUB_STATUS_CONFIG = 8'hAE;
    localparam logic [7:0] OFF_PCMD = 8'hCF;
    localparam logic [7:0] OFF_IDX = 8'hD4;
    localparam logic [7:0] OFF_CHG = 8'hD5;
    localparam logic [7:0] OFF_VIEW = 8'hD7;
    localparam logic [7:0] OFF_IFLG = 8'hE8;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] PWR_MASK = 8'h3E;
    // port state view bits
    localparam int SV_DP = 7;
    localparam int SV_DM = 6;
    localparam int SV_PWR = 5;
    localparam int SV_LS = 4;
    localparam int SV_RST = 3;
    localparam int SV_SUSP = 2;
    localparam int SV_ENA = 1;
    localparam int SV_CONN = 0;
    // change flag positions in the register
    localparam int CF_RST = 4;
    localparam int CF_SUSP = 2;
    localparam int CF_ENA = 1;
    localparam int CF_CONN = 0;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int RST_CNT_W = 16;
    // port commands
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ENABLE = 3'h1,
        CMD_DISABLE = 3'h2,
        CMD_RESET = 3'h3,
        CMD_SUSPEND = 3'h4,
        CMD_RESUME = 3'h5
    } uhr_cmd_t;
    // downstream port states
    typedef enum logic [2:0] {
        PS_OFF = 3'h0,
        PS_DISC = 3'h1,
        PS_DIS = 3'h2,
        PS_ENA = 3'h3,
        PS_SUSP = 3'h4
    } uhr_pstate_t;
    // repeater connectivity
    typedef enum logic [1:0] {
        REP_IDLE = 2'h0,
        REP_DOWN = 2'h1,
        REP_UP = 2'h2
    } uhr_rep_t;
    // per-port line sense from the transceiver
    typedef struct packed {
        logic connect;
        logic low_speed;
        logic dplus;
        logic dminus;
        logic sop;
        logic eop;
    } uhr_port_t;
    // cpu special function register access
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } uhr_sfr_t;
endpackage
`default_nettype wire

// ### test/uhr_host_model.sv
// host model driving packet framing onto the root port
`default_nettype none
module uhr_host_model (
    input wire logic core_clk, // core clock
    output logic up_sop, // start of packet
    output logic up_eop, // end of packet
    output logic up_pre // low-speed preamble
);
    timeunit 1ns;
    timeprecision 1ps;
    // framing lines idle from time zero
    initial
    begin
        {up_sop, up_pre, up_eop} = 3'h0;
    end
    // one framing pulse a cycle long: 0 start, 1 preamble, 2 end
    task automatic pulse(input int k);
        @(negedge core_clk);
        {up_sop, up_pre, up_eop} = 3'(3'h4 >> k);
        @(negedge core_clk);
        {up_sop, up_pre, up_eop} = 3'h0;
    endtask
endmodule
`default_nettype wire

// ### test/uhr_hub_repeater_bench.sv
// self-checking bench for the hub repeater, port states and hub registers
`default_nettype none
module uhr_hub_repeater_bench;
    import uhr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_b, hub_suspended, up_sop, up_eop, up_pre, resume_q;
    uhr_sfr_t sfr;
    uhr_port_t [NUM_DN:1] port_in;
    logic [7:0] sfr_rdata_q, hub_addr_q;
    logic [NUM_DN:1] dn_power_q, dn_fwd_q, dn_oe_q, dn_reset_q, dn_invert_q;
    logic [2:0] up_sel_q;
    logic [7:0] offs [8] = '{OFF_HADDR, OFF_PWR, OFF_IE, OFF_HUB_STATUS_CONFIG, OFF_IDX, OFF_IFLG, OFF_PCMD, 8'h80};
    int error_cnt, cmp_count, n, wake_n;
    uhr_hub_repeater #(.PORT_RESET_US(1)) i_uhr_hub_repeater (.core_clk(core_clk), .rst_b(rst_b), .sfr(sfr),
        .sfr_rdata_q(sfr_rdata_q), .hub_suspended(hub_suspended), .up_sop(up_sop), .up_eop(up_eop),
        .up_pre(up_pre), .port_in(port_in), .dn_power_q(dn_power_q), .dn_fwd_q(dn_fwd_q), .dn_oe_q(dn_oe_q),
        .dn_reset_q(dn_reset_q), .dn_invert_q(dn_invert_q), .up_sel_q(up_sel_q), .resume_q(resume_q),
        .hub_addr_q(hub_addr_q));
    uhr_host_model i_uhr_host_model (.core_clk(core_clk), .up_sop(up_sop), .up_eop(up_eop), .up_pre(up_pre));
    // clock and watchdog
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (8000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end
    // count one-cycle wake pulses
    always @(posedge core_clk)
        if (resume_q === 1'b1)
            wake_n <= wake_n + 1;
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge core_clk);
        sfr.wr = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge core_clk);
        sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge core_clk);
        sfr.rd = 1'b0;
        chk($sformatf("reg %h", a), sfr_rdata_q & m, e);
    endtask
    task automatic view(input logic [7:0] p, input logic [7:0] e, input logic [7:0] m);
        wr(OFF_IDX, p);
        rc(OFF_VIEW, e, m);
    endtask
    task automatic cmd(input logic [7:0] p, input uhr_cmd_t c);
        wr(OFF_IDX, p);
        wr(OFF_PCMD, 8'(c));
    endtask
    // start or end pulse on one downstream port
    task automatic upk(input int p, input logic e);
        @(negedge core_clk);
        port_in[p].sop = !e;
        port_in[p].eop = e;
        @(negedge core_clk);
        port_in[p] = '{connect: port_in[p].connect, low_speed: port_in[p].low_speed, default: 1'b0};
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {rst_b, hub_suspended} = 2'h0;
        sfr = '0;
        port_in = '0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        foreach (offs[i]) rc(offs[i], REG_RST, 8'hFF);
        chk("pwr", 8'(dn_power_q), 8'h01);
        chk("oe", 8'(dn_oe_q), 8'h00);
        view(8'h00, 8'h23, 8'hFF);
        view(8'h01, 8'h21, 8'hFF);
        view(8'h02, 8'h00, 8'hFF);
        wr(OFF_PWR, 8'hFF);
        rc(OFF_PWR, PWR_MASK, 8'hFF);
        chk("pwr", 8'(dn_power_q), 8'h1F);
        wr(OFF_PWR, 8'h0E);
        port_in[2].connect = 1'b1;
        port_in[3].connect = 1'b1;
        port_in[3].low_speed = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("pwr", 8'(dn_power_q), 8'h07);
        view(8'h03, 8'h31, 8'hFF);
        rc(OFF_CHG, 8'h01, 8'hFF);
        wr(OFF_CHG, 8'h01);
        rc(OFF_CHG, 8'h00, 8'hFF);
        i_uhr_host_model.pulse(0);
        chk("fwd", 8'(dn_fwd_q), 8'h00);
        i_uhr_host_model.pulse(2);
        for (int p = 1; p <= 3; p++) cmd(8'(p), CMD_ENABLE);
        view(8'h02, 8'h23, 8'hFF);
        chk("inv", 8'(dn_invert_q), 8'h00);
        i_uhr_host_model.pulse(0);
        chk("fwd", 8'(dn_fwd_q), 8'h03);
        i_uhr_host_model.pulse(2);
        chk("fwd", 8'(dn_fwd_q), 8'h00);
        i_uhr_host_model.pulse(0);
        i_uhr_host_model.pulse(1);
        chk("fwd", 8'(dn_fwd_q), 8'h07);
        chk("inv", 8'(dn_invert_q), 8'h04);
        i_uhr_host_model.pulse(2);
        @(negedge core_clk);
        {port_in[2].sop, port_in[3].sop, port_in[4].sop, port_in[5].sop} = 4'hF;
        @(negedge core_clk);
        {port_in[2].sop, port_in[3].sop, port_in[4].sop, port_in[5].sop} = 4'h0;
        chk("sel", 8'(up_sel_q), 8'h02);
        upk(2, 1'b1);
        chk("sel", 8'(up_sel_q), 8'h00);
        upk(3, 1'b0);
        chk("sel", 8'(up_sel_q), 8'h03);
        chk("inv", 8'(dn_invert_q), 8'h04);
        upk(3, 1'b1);
        i_uhr_host_model.pulse(0);
        cmd(8'h02, CMD_SUSPEND);
        chk("fwd", 8'(dn_fwd_q), 8'h03);
        i_uhr_host_model.pulse(2);
        view(8'h02, 8'h04, 8'h04);
        upk(2, 1'b0);
        chk("sel", 8'(up_sel_q), 8'h00);
        upk(2, 1'b1);
        i_uhr_host_model.pulse(0);
        chk("fwd", 8'(dn_fwd_q), 8'h01);
        i_uhr_host_model.pulse(2);
        hub_suspended = 1'b1;
        upk(2, 1'b0);
        upk(2, 1'b1);
        hub_suspended = 1'b0;
        chk("wake", 8'(wake_n), 8'h01);
        cmd(8'h02, CMD_RESUME);
        rc(OFF_CHG, 8'h04, 8'h04);
        view(8'h02, 8'h02, 8'h06);
        cmd(8'h03, CMD_DISABLE);
        i_uhr_host_model.pulse(0);
        i_uhr_host_model.pulse(1);
        chk("fwd", 8'(dn_fwd_q), 8'h03);
        i_uhr_host_model.pulse(2);
        cmd(8'h03, CMD_RESET);
        @(negedge core_clk);
        chk("rst", 8'(dn_reset_q & dn_oe_q), 8'h04);
        n = 0;
        while (dn_reset_q[3] === 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("rstlen", 8'(n >= 190 && n <= 210), 8'h01);
        view(8'h03, 8'h02, 8'h0A);
        rc(OFF_CHG, 8'h10, 8'h10);
        view(8'h06, 8'h00, 8'hFF);
        rc(OFF_CHG, 8'h00, 8'hFF);
        wr(OFF_PCMD, 8'(CMD_DISABLE));
        view(8'h03, 8'h02, 8'h02);
        cmd(8'h03, CMD_DISABLE);
        hub_suspended = 1'b1;
        port_in[3].connect = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("wake", 8'(wake_n), 8'h02);
        hub_suspended = 1'b0;
        view(8'h03, 8'h00, 8'h03);
        rc(OFF_CHG, 8'h01, 8'h01);
        wr(OFF_HADDR, 8'h5A);
        rc(OFF_HADDR, 8'h5A, 8'hFF);
        chk("addr", hub_addr_q, 8'h5A);
        upk(1, 1'b0);
        chk("sel", 8'(up_sel_q), 8'h01);
        upk(1, 1'b1);
        chk("sel", 8'(up_sel_q), 8'h00);
        // line levels on every port, connect on unpowered ports
        for (int p = 1; p <= NUM_DN; p++)
        begin
            port_in[p].dplus = p[0];
            port_in[p].dminus = !p[0];
            if (p > 3)
                {port_in[p].connect, port_in[p].low_speed} = 2'h3;
            view(8'(p), {p[0], !p[0], 6'h00}, 8'hC0);
        end
        view(8'h05, 8'h10, 8'h31);
        report_and_stop();
    end
endmodule
`default_nettype wire
